// ==== hw/drive_map_pkg.sv ====
package drive_map_pkg;

    // Common-area word addresses
    localparam logic [15:0] ADDR_RUN_CONDITION_FLAGS   = 16'h000e;
    localparam logic [15:0] ADDR_FAULT_CAUSE_FLAGS     = 16'h000f;
    localparam logic [15:0] ADDR_DIGITAL_INPUT_LEVELS  = 16'h0010;
    localparam logic [15:0] ADDR_DIGITAL_OUTPUT_LEVELS = 16'h0011;
    localparam logic [15:0] ADDR_VOLTAGE_INPUT_ONE     = 16'h0012;
    localparam logic [15:0] ADDR_VOLTAGE_INPUT_TWO     = 16'h0013;
    localparam logic [15:0] ADDR_CURRENT_LOOP_INPUT    = 16'h0014;
    localparam logic [15:0] ADDR_SHAFT_SPEED           = 16'h0015;
    localparam logic [15:0] ADDR_SPEED_UNIT_SELECT     = 16'h001a;
    localparam logic [15:0] ADDR_MOTOR_POLE_COUNT      = 16'h001b;
    localparam logic [15:0] ADDR_CUSTOMER_BUILD_TAG    = 16'h001c;

    // Run word bit positions
    localparam int RUN_SPEED_ARRIVAL_BIT   = 6;
    localparam int RUN_DC_BRAKING_BIT      = 7;
    localparam int RUN_STOPPING_BIT        = 8;
    localparam int RUN_BRAKE_OPEN_BIT      = 10;
    localparam int RUN_FWD_REQUEST_BIT     = 11;
    localparam int RUN_REV_REQUEST_BIT     = 12;
    localparam int REMOTE_RUN_SOURCE_BIT   = 13;
    localparam int REMOTE_SPEED_SOURCE_BIT = 14;

    // Fault word bit positions
    localparam int SURGE_A_BIT        = 0;
    localparam int HIGH_VOLTAGE_BIT   = 1;
    localparam int OUTSIDE_FAULT_BIT  = 2;
    localparam int COAST_STOP_BIT     = 3;
    localparam int UNDERVOLTAGE_BIT   = 4;
    localparam int EARTH_HEAT_BIT     = 6;
    localparam int MOTOR_HEAT_BIT     = 7;
    localparam int LOAD_EXCESS_BIT    = 8;
    localparam int SELFTEST_BIT       = 10;
    localparam int SURGE_B_BIT        = 12;
    localparam int ACCESSORY_CARD_BIT = 13;
    localparam int PHASE_LOSS_BIT     = 14;
    localparam int CURRENT_EXCESS_BIT = 15;

    // Command sources that count as remote
    localparam logic [1:0] RUN_SRC_OPTION     = 2'h2;
    localparam logic [1:0] RUN_SRC_SERIAL     = 2'h3;
    localparam logic [4:0] SPEED_SRC_SERIAL   = 5'h1c;
    localparam logic [4:0] SPEED_SRC_OPTION   = 5'h1d;

    // Parameter windows: 0x9100 .. 0x97ff
    localparam logic [4:0] PARAM_AREA_PREFIX  = 5'h12;
    localparam logic [2:0] GROUP_DRIVE        = 3'h1;
    localparam logic [2:0] GROUP_APPLICATION  = 3'h7;
    localparam int         PARAM_GROUP_WORDS  = 256;
    localparam int         PARAM_GROUP_COUNT  = 7;

    // Reset value of response words and parameter write data
    localparam logic [15:0] WORD_RESET        = 16'h0000;

    typedef enum logic [1:0] {
        ACC_NONE,
        ACC_STATUS,
        ACC_PARAM,
        ACC_ERROR
    } access_kind_t;

endpackage

// ==== hw/status_word_pack.sv ====
// Builds the run-condition and fault-cause words from live inputs
module status_word_pack
    import drive_map_pkg::*;
(
    input  wire logic [5:0]  i_base_status,
    input  wire logic        i_speed_arrived,
    input  wire logic        i_dc_braking,
    input  wire logic        i_stopping,
    input  wire logic        i_brake_open,
    input  wire logic        i_fwd_run_cmd,
    input  wire logic        i_rev_run_cmd,
    input  wire logic [1:0]  i_run_source,
    input  wire logic [4:0]  i_speed_source,
    input  wire logic [15:0] i_trips,
    output      logic [15:0] o_run_word,
    output      logic [15:0] o_fault_word
);

    logic remote_run_source_flag;
    logic remote_speed_source_flag;

    // Remote means serial link or option card
    assign remote_run_source_flag = (i_run_source == RUN_SRC_SERIAL) ||
                                    (i_run_source == RUN_SRC_OPTION);
    assign remote_speed_source_flag = (i_speed_source == SPEED_SRC_SERIAL) ||
                                      (i_speed_source == SPEED_SRC_OPTION);

    // Run word assembly
    always_comb begin
        o_run_word = WORD_RESET;
        o_run_word[5:0] = i_base_status;
        o_run_word[RUN_SPEED_ARRIVAL_BIT] = i_speed_arrived;
        o_run_word[RUN_DC_BRAKING_BIT]    = i_dc_braking;
        o_run_word[RUN_STOPPING_BIT]      = i_stopping;
        o_run_word[RUN_BRAKE_OPEN_BIT]    = i_brake_open;
        o_run_word[RUN_FWD_REQUEST_BIT]   = i_fwd_run_cmd;
        o_run_word[RUN_REV_REQUEST_BIT]   = i_rev_run_cmd;
        o_run_word[REMOTE_RUN_SOURCE_BIT] = remote_run_source_flag;
        o_run_word[REMOTE_SPEED_SOURCE_BIT] = remote_speed_source_flag;
    end

    // Fault word: trip vector already in bit order, reserved bits forced 0
    always_comb begin
        o_fault_word = i_trips;
        o_fault_word[5]  = 1'b0;
        o_fault_word[9]  = 1'b0;
        o_fault_word[11] = 1'b0;
    end

endmodule // status_word_pack

// ==== hw/param_store.sv ====
// Parameter words for all groups, one-cycle read
module param_store #(
    parameter int GROUPS = 7,
    parameter int WORDS  = 256
) (
    input  wire logic                         i_clk,
    input  wire logic                         i_wr,
    input  wire logic [$clog2(GROUPS*WORDS)-1:0] i_index,
    input  wire logic [15:0]                  i_wdata,
    output      logic [15:0]                  o_rdata
);

    // Index packing assumes 256-word windows and at most seven groups
    if (GROUPS < 1 || GROUPS > 7 || WORDS != 256) begin : g_bad_geometry
        $error("param_store: unsupported geometry");
    end

    logic [15:0] mem [GROUPS*WORDS];

    // Write-first is not needed: read shows the stored word before update
    always_ff @(posedge i_clk) begin
        if (i_wr) begin
            mem[i_index] <= i_wdata;
        end
        o_rdata <= mem[i_index];
    end

endmodule // param_store

// ==== hw/drive_serial_status_map.sv ====
// Serial-link register map: live status words and parameter windows
module drive_serial_status_map
    import drive_map_pkg::*;
#(
    parameter int GROUPS = PARAM_GROUP_COUNT
) (
    input  wire logic        I_SYS_CLK,
    input  wire logic        I_RESET,
    // Register request from the serial protocol engine
    input  wire logic        I_REQ_VALID,
    input  wire logic        I_REQ_WRITE,
    input  wire logic [15:0] I_REQ_ADDR,
    input  wire logic [15:0] I_REQ_WDATA,
    output      logic        O_RSP_VALID,
    output      logic [15:0] O_RSP_RDATA,
    output      logic        O_RSP_ERROR,
    // Parameter write notification to the drive
    output      logic        O_PARAM_WR,
    output      logic [2:0]  O_PARAM_GROUP,
    output      logic [7:0]  O_PARAM_CODE,
    output      logic [15:0] O_PARAM_DATA,
    // Drive condition
    input  wire logic [5:0]  I_BASE_STATUS,
    input  wire logic        I_SPEED_ARRIVED,
    input  wire logic        I_DC_BRAKING,
    input  wire logic        I_STOPPING,
    input  wire logic        I_BRAKE_OPEN,
    input  wire logic        I_FWD_RUN_CMD,
    input  wire logic        I_REV_RUN_CMD,
    input  wire logic [1:0]  I_RUN_SOURCE,
    input  wire logic [4:0]  I_SPEED_SOURCE,
    // Trip causes
    input  wire logic        I_CURRENT_SURGE_TRIP_A,
    input  wire logic        I_BUS_HIGH_VOLTAGE_TRIP,
    input  wire logic        I_OUTSIDE_FAULT_TRIP,
    input  wire logic        I_COAST_STOP_INPUT_TRIP,
    input  wire logic        I_UNDERVOLTAGE_TRIP,
    input  wire logic        I_EARTH_LEAK_TRIP,
    input  wire logic        I_DRIVE_HEAT_TRIP,
    input  wire logic        I_MOTOR_HEAT_TRIP,
    input  wire logic        I_LOAD_EXCESS_TRIP,
    input  wire logic        I_HARDWARE_SELFTEST_TRIP,
    input  wire logic        I_CURRENT_SURGE_TRIP_B,
    input  wire logic        I_ACCESSORY_CARD_FAULT,
    input  wire logic        I_PHASE_LOSS_TRIP,
    input  wire logic        I_DRIVE_CURRENT_EXCESS_TRIP,
    // Terminals and readbacks
    input  wire logic [7:0]  I_INPUT_TERMINALS,
    input  wire logic [3:0]  I_AUX_OUTPUTS,
    input  wire logic        I_RELAY_OUTPUT,
    input  wire logic [15:0] I_VOLTAGE_INPUT_ONE,
    input  wire logic [15:0] I_VOLTAGE_INPUT_TWO,
    input  wire logic [15:0] I_CURRENT_LOOP_INPUT,
    input  wire logic [15:0] I_SHAFT_SPEED,
    input  wire logic        I_SPEED_UNIT_RPM,
    input  wire logic [15:0] I_MOTOR_POLE_COUNT,
    input  wire logic [15:0] I_CUSTOMER_BUILD_TAG
);

    localparam int IDX_W = $clog2(GROUPS * PARAM_GROUP_WORDS);

    // Decode covers exactly the seven group windows
    if (GROUPS != PARAM_GROUP_COUNT) begin : g_bad_groups
        $error("drive_serial_status_map: GROUPS must be 7");
    end

    logic [15:0]  trips;
    logic [15:0]  run_word;
    logic [15:0]  fault_word;
    logic [15:0]  input_word;
    logic [15:0]  output_word;
    logic [2:0]   group_sel;
    logic [7:0]   code_sel;
    logic         in_param_area;
    logic         status_hit;
    logic [15:0]  status_data;
    logic [IDX_W-1:0] param_index;
    logic         param_wr;
    logic [15:0]  param_rdata;
    access_kind_t next_kind;
    access_kind_t kind;
    logic [15:0]  status_hold;

    // Trip vector in fault-word bit order; drive overheat shares earth-fault bit
    always_comb begin
        trips = WORD_RESET;
        trips[SURGE_A_BIT]        = I_CURRENT_SURGE_TRIP_A;
        trips[HIGH_VOLTAGE_BIT]   = I_BUS_HIGH_VOLTAGE_TRIP;
        trips[OUTSIDE_FAULT_BIT]  = I_OUTSIDE_FAULT_TRIP;
        trips[COAST_STOP_BIT]     = I_COAST_STOP_INPUT_TRIP;
        trips[UNDERVOLTAGE_BIT]   = I_UNDERVOLTAGE_TRIP;
        trips[EARTH_HEAT_BIT]     = I_EARTH_LEAK_TRIP |
                                    I_DRIVE_HEAT_TRIP;
        trips[MOTOR_HEAT_BIT]     = I_MOTOR_HEAT_TRIP;
        trips[LOAD_EXCESS_BIT]    = I_LOAD_EXCESS_TRIP;
        trips[SELFTEST_BIT]       = I_HARDWARE_SELFTEST_TRIP;
        trips[SURGE_B_BIT]        = I_CURRENT_SURGE_TRIP_B;
        trips[ACCESSORY_CARD_BIT] = I_ACCESSORY_CARD_FAULT;
        trips[PHASE_LOSS_BIT]     = I_PHASE_LOSS_TRIP;
        trips[CURRENT_EXCESS_BIT] = I_DRIVE_CURRENT_EXCESS_TRIP;
    end

    status_word_pack u_pack (
        .i_base_status   (I_BASE_STATUS),
        .i_speed_arrived (I_SPEED_ARRIVED),
        .i_dc_braking    (I_DC_BRAKING),
        .i_stopping      (I_STOPPING),
        .i_brake_open    (I_BRAKE_OPEN),
        .i_fwd_run_cmd   (I_FWD_RUN_CMD),
        .i_rev_run_cmd   (I_REV_RUN_CMD),
        .i_run_source    (I_RUN_SOURCE),
        .i_speed_source  (I_SPEED_SOURCE),
        .i_trips         (trips),
        .o_run_word      (run_word),
        .o_fault_word    (fault_word)
    );

    // Terminal words: inputs low byte, outputs low nibble plus relay bit 7
    assign input_word  = {8'h00, I_INPUT_TERMINALS};
    assign output_word = {8'h00, I_RELAY_OUTPUT, 3'h0, I_AUX_OUTPUTS};

    // Parameter address split: group base plus code number
    assign group_sel     = I_REQ_ADDR[10:8];
    assign code_sel      = I_REQ_ADDR[7:0];
    assign in_param_area = (I_REQ_ADDR[15:11] == PARAM_AREA_PREFIX) &&
                           (group_sel >= GROUP_DRIVE) &&
                           (group_sel <= GROUP_APPLICATION);
    assign param_index   = IDX_W'({group_sel - GROUP_DRIVE, code_sel});
    assign param_wr      = I_REQ_VALID && I_REQ_WRITE &&
                           in_param_area;

    // Live status decode, sampled at the request edge
    always_comb begin
        status_hit  = 1'b1;
        status_data = WORD_RESET;
        unique case (I_REQ_ADDR)
            ADDR_RUN_CONDITION_FLAGS:   status_data = run_word;
            ADDR_FAULT_CAUSE_FLAGS:     status_data = fault_word;
            ADDR_DIGITAL_INPUT_LEVELS:  status_data = input_word;
            ADDR_DIGITAL_OUTPUT_LEVELS: status_data = output_word;
            ADDR_VOLTAGE_INPUT_ONE:     status_data = I_VOLTAGE_INPUT_ONE;
            ADDR_VOLTAGE_INPUT_TWO:     status_data = I_VOLTAGE_INPUT_TWO;
            ADDR_CURRENT_LOOP_INPUT:    status_data = I_CURRENT_LOOP_INPUT;
            ADDR_SHAFT_SPEED:           status_data = I_SHAFT_SPEED;
            ADDR_SPEED_UNIT_SELECT:
                status_data = {15'h0, I_SPEED_UNIT_RPM};
            ADDR_MOTOR_POLE_COUNT:      status_data = I_MOTOR_POLE_COUNT;
            ADDR_CUSTOMER_BUILD_TAG:    status_data = I_CUSTOMER_BUILD_TAG;
            default:                    status_hit  = 1'b0;
        endcase
    end

    // Classify the request; writes to read-only words are refused
    always_comb begin
        if (!I_REQ_VALID) begin
            next_kind = ACC_NONE;
        end else if (in_param_area) begin
            next_kind = ACC_PARAM;
        end else if (status_hit && !I_REQ_WRITE) begin
            next_kind = ACC_STATUS;
        end else begin
            next_kind = ACC_ERROR;
        end
    end

    param_store #(
        .GROUPS (GROUPS),
        .WORDS  (PARAM_GROUP_WORDS)
    ) u_params (
        .i_clk   (I_SYS_CLK),
        .i_wr    (param_wr),
        .i_index (param_index),
        .i_wdata (I_REQ_WDATA),
        .o_rdata (param_rdata)
    );

    // Access kind and status word held for the answer cycle
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            kind        <= ACC_NONE;
            status_hold <= WORD_RESET;
        end else begin
            kind        <= next_kind;
            status_hold <= status_data;
        end
    end

    // Parameter write notice, one cycle after the request
    always_ff @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            O_PARAM_WR    <= 1'b0;
            O_PARAM_GROUP <= 3'h0;
            O_PARAM_CODE  <= 8'h00;
            O_PARAM_DATA  <= WORD_RESET;
        end else begin
            O_PARAM_WR <= param_wr;
            if (param_wr) begin
                O_PARAM_GROUP <= group_sel;
                O_PARAM_CODE  <= code_sel;
                O_PARAM_DATA  <= I_REQ_WDATA;
            end
        end
    end

    // Answer one cycle after the request
    assign O_RSP_VALID = (kind != ACC_NONE);
    assign O_RSP_ERROR = (kind == ACC_ERROR);

    // Read data: status words live, parameters from the store
    always_comb begin
        unique case (kind)
            ACC_STATUS: O_RSP_RDATA = status_hold;
            ACC_PARAM:  O_RSP_RDATA = param_rdata;
            ACC_NONE,
            ACC_ERROR:  O_RSP_RDATA = WORD_RESET;
        endcase
    end

endmodule // drive_serial_status_map

// ==== dv/drive_map_asserts.sv ====
// Protocol and decode checks on the top-level ports
module drive_map_asserts (
    input wire logic        I_SYS_CLK,
    input wire logic        I_RESET,
    input wire logic        I_REQ_VALID,
    input wire logic        I_REQ_WRITE,
    input wire logic [15:0] I_REQ_ADDR,
    input wire logic [15:0] I_REQ_WDATA,
    input wire logic        O_RSP_VALID,
    input wire logic [15:0] O_RSP_RDATA,
    input wire logic        O_RSP_ERROR,
    input wire logic        O_PARAM_WR,
    input wire logic [2:0]  O_PARAM_GROUP,
    input wire logic [7:0]  O_PARAM_CODE,
    input wire logic [15:0] O_PARAM_DATA,
    input wire logic [7:0]  I_INPUT_TERMINALS,
    input wire logic [15:0] I_SHAFT_SPEED
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RESET);
    // Request decode helpers
    wire logic win = I_REQ_ADDR[15:11] == 5'h12 && I_REQ_ADDR[10:8] != 3'h0;
    wire logic ro  = I_REQ_ADDR inside {[16'h000e:16'h0015],
                                        [16'h001a:16'h001c]};
    wire logic pwr = I_REQ_VALID && I_REQ_WRITE && win;
    wire logic rd  = I_REQ_VALID && !I_REQ_WRITE;

    a_rsp_next: assert property (I_REQ_VALID |=> O_RSP_VALID)
        else $error("no response one cycle after request");
    a_rsp_cause: assert property (O_RSP_VALID |-> $past(I_REQ_VALID))
        else $error("response without request");
    a_param_decode: assert property (
        pwr |=> O_PARAM_WR && !O_RSP_ERROR)
        else $error("window write not passed on");
    a_param_cause: assert property (O_PARAM_WR |-> $past(pwr))
        else $error("parameter write without window write");
    a_param_fields: assert property (
        O_PARAM_WR |-> {5'h12, O_PARAM_GROUP, O_PARAM_CODE} ==
        $past(I_REQ_ADDR) && O_PARAM_DATA == $past(I_REQ_WDATA))
        else $error("parameter group, code or data wrong");
    a_param_hold: assert property (!O_PARAM_WR |-> $stable(O_PARAM_DATA))
        else $error("parameter data moved without write");
    a_ro_write: assert property (
        I_REQ_VALID && I_REQ_WRITE && ro |=> O_RSP_ERROR &&
        O_RSP_RDATA == 16'h0000 && !O_PARAM_WR)
        else $error("write to read-only word accepted");
    a_unmapped_refused: assert property (
        I_REQ_VALID && !win && !ro |=> O_RSP_ERROR ##1
        (!O_RSP_ERROR || $past(I_REQ_VALID)))
        else $error("unmapped access not refused");
    a_term_read: assert property (
        rd && I_REQ_ADDR == 16'h0010 |=> !O_RSP_ERROR &&
        O_RSP_RDATA == {8'h00, $past(I_INPUT_TERMINALS)})
        else $error("terminal word not live");
    a_speed_read: assert property (
        rd && I_REQ_ADDR == 16'h0015 |=> O_RSP_RDATA == $past(I_SHAFT_SPEED))
        else $error("speed word not live");

    c_param_write: cover property (O_PARAM_WR);
    c_refused: cover property (O_RSP_ERROR);
    c_read_ok: cover property (O_RSP_VALID && !O_RSP_ERROR);
endmodule // drive_map_asserts

// ==== dv/serial_master.sv ====
// Network master: one register request per call
module serial_master (
    input  wire logic        I_SYS_CLK,
    output      logic        I_REQ_VALID,
    output      logic        I_REQ_WRITE,
    output      logic [15:0] I_REQ_ADDR,
    output      logic [15:0] I_REQ_WDATA,
    input  wire logic        O_RSP_VALID,
    input  wire logic [15:0] O_RSP_RDATA,
    input  wire logic        O_RSP_ERROR
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle bus at time zero
    initial begin
        I_REQ_VALID = 1'b0;
        I_REQ_WRITE = 1'b0;
        I_REQ_ADDR  = 16'h0000;
        I_REQ_WDATA = 16'h0000;
    end
    // Base plus code address issued as-is
    task automatic xfer(input logic w, input logic [15:0] a, d,
                        output logic [15:0] rdat, output logic err,
                        output logic ok);
        @(posedge I_SYS_CLK);
        I_REQ_VALID <= 1'b1;
        I_REQ_WRITE <= w;
        I_REQ_ADDR  <= a;
        I_REQ_WDATA <= d;
        @(posedge I_SYS_CLK);
        // Released lines show a changed value, not the old one
        I_REQ_VALID <= 1'b0;
        I_REQ_WRITE <= ~w;
        I_REQ_ADDR  <= ~a;
        I_REQ_WDATA <= ~d;
        #1;
        rdat = O_RSP_RDATA;
        err  = O_RSP_ERROR;
        ok   = O_RSP_VALID;
    endtask
endmodule // serial_master

// ==== dv/test_drive_serial_status_map.sv ====
// Register map bench: table of live reads, then refusals and windows
module test_drive_serial_status_map import drive_map_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [15:0] a;
        logic [1:0]  r;
        logic [4:0]  s;
        logic [15:0] v;
        logic [15:0] e;
    } row_t;
    logic        I_SYS_CLK = 1'b0;
    logic        I_RESET   = 1'b1;
    logic [15:0] v  = 16'h0000;
    logic [1:0]  rs = 2'h0;
    logic [4:0]  ss = 5'h00;
    logic [15:0] rd;
    logic        er, ok;
    int          failures = 0;
    int          compares = 0;
    wire logic        I_REQ_VALID, I_REQ_WRITE, O_RSP_VALID, O_RSP_ERROR;
    wire logic        O_PARAM_WR;
    wire logic [15:0] I_REQ_ADDR, I_REQ_WDATA, O_RSP_RDATA, O_PARAM_DATA;
    wire logic [2:0]  O_PARAM_GROUP;
    wire logic [7:0]  O_PARAM_CODE;
    wire logic [15:0] param_addr = {5'h12, O_PARAM_GROUP, O_PARAM_CODE};
    // Drive condition spread from one stimulus word
    wire logic [5:0]  I_BASE_STATUS = v[5:0];
    wire logic I_SPEED_ARRIVED = v[6], I_DC_BRAKING = v[7];
    wire logic I_STOPPING = v[8], I_BRAKE_OPEN = v[10];
    wire logic I_FWD_RUN_CMD = v[11], I_REV_RUN_CMD = v[12];
    wire logic [1:0]  I_RUN_SOURCE = rs;
    wire logic [4:0]  I_SPEED_SOURCE = ss;
    wire logic I_CURRENT_SURGE_TRIP_A = v[0], I_BUS_HIGH_VOLTAGE_TRIP = v[1];
    wire logic I_OUTSIDE_FAULT_TRIP = v[2], I_COAST_STOP_INPUT_TRIP = v[3];
    wire logic I_UNDERVOLTAGE_TRIP = v[4], I_EARTH_LEAK_TRIP = v[6];
    wire logic I_DRIVE_HEAT_TRIP = v[9], I_MOTOR_HEAT_TRIP = v[7];
    wire logic I_LOAD_EXCESS_TRIP = v[8], I_HARDWARE_SELFTEST_TRIP = v[10];
    wire logic I_CURRENT_SURGE_TRIP_B = v[12], I_ACCESSORY_CARD_FAULT = v[13];
    wire logic I_PHASE_LOSS_TRIP = v[14], I_DRIVE_CURRENT_EXCESS_TRIP = v[15];
    wire logic [7:0]  I_INPUT_TERMINALS = v[7:0];
    wire logic [3:0]  I_AUX_OUTPUTS = v[3:0];
    wire logic        I_RELAY_OUTPUT = v[7], I_SPEED_UNIT_RPM = v[0];
    wire logic [15:0] I_VOLTAGE_INPUT_ONE = v, I_VOLTAGE_INPUT_TWO = ~v;
    wire logic [15:0] I_CURRENT_LOOP_INPUT = v ^ 16'h5a5a;
    wire logic [15:0] I_SHAFT_SPEED = {v[7:0], v[15:8]};
    wire logic [15:0] I_MOTOR_POLE_COUNT = v + 16'h0001;
    wire logic [15:0] I_CUSTOMER_BUILD_TAG = v - 16'h0001;
    // Live reads: address, sources, stimulus, expected word
    row_t rows [18] = '{
        '{16'h000e, 2'h0, 5'h00, 16'h1fff, 16'h1dff},
        '{16'h000e, 2'h2, 5'h1c, 16'h0000, 16'h6000},
        '{16'h000e, 2'h3, 5'h00, 16'h0000, 16'h2000},
        '{16'h000e, 2'h0, 5'h1d, 16'h0000, 16'h4000},
        '{16'h000e, 2'h1, 5'h1b, 16'h0000, 16'h0000},
        '{16'h000f, 2'h0, 5'h00, 16'hffff, 16'hf5df},
        '{16'h000f, 2'h0, 5'h00, 16'h0040, 16'h0040},
        '{16'h000f, 2'h0, 5'h00, 16'h0200, 16'h0040},
        '{16'h000f, 2'h0, 5'h00, 16'h0a20, 16'h0040},
        '{16'h0010, 2'h0, 5'h00, 16'ha5ff, 16'h00ff},
        '{16'h0011, 2'h0, 5'h00, 16'h00ff, 16'h008f},
        '{16'h0012, 2'h0, 5'h00, 16'h1234, 16'h1234},
        '{16'h0013, 2'h0, 5'h00, 16'h1234, 16'hedcb},
        '{16'h0014, 2'h0, 5'h00, 16'h1234, 16'h486e},
        '{16'h0015, 2'h0, 5'h00, 16'h1234, 16'h3412},
        '{16'h001a, 2'h0, 5'h00, 16'h0001, 16'h0001},
        '{16'h001b, 2'h0, 5'h00, 16'h1234, 16'h1235},
        '{16'h001c, 2'h0, 5'h00, 16'h1234, 16'h1233}};
    logic [15:0] bad [5] = '{16'h000d, 16'h0016, 16'h001d, 16'h90ff,
                             16'h9800};

    drive_serial_status_map dut (.*);
    serial_master m (.*);

    always #2 I_SYS_CLK = ~I_SYS_CLK;

    task automatic chk16(input string n, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk1(input string n, input logic e, g);
        compares++;
        if (g !== e) begin
            failures++;
            $display("ERROR %s expected %b seen %b", n, e, g);
        end
    endtask
    // One request, answer expected one cycle later
    task automatic xf(input logic w, input logic [15:0] a, d);
        m.xfer(w, a, d, rd, er, ok);
        chk1("rsp_valid", 1'b1, ok);
    endtask
    task automatic end_sim;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Hang guard
    initial begin
        #100000;
        failures++;
        end_sim();
    end
    initial begin
        repeat (3) @(posedge I_SYS_CLK);
        #1;
        chk1("reset rsp_valid", 1'b0, O_RSP_VALID);
        chk16("reset param_data", 16'h0000, O_PARAM_DATA);
        @(posedge I_SYS_CLK);
        I_RESET <= 1'b0;
        $display("test reset done");
        foreach (rows[i]) begin
            @(posedge I_SYS_CLK);
            v  <= rows[i].v;
            rs <= rows[i].r;
            ss <= rows[i].s;
            xf(1'b0, rows[i].a, 16'h0000);
            if (rows[i].a == ADDR_RUN_CONDITION_FLAGS) begin
                chk16("run word", rows[i].e, rd);
            end else if (rows[i].a == ADDR_FAULT_CAUSE_FLAGS) begin
                chk16("fault word", rows[i].e, rd);
            end else begin
                chk16("live word", rows[i].e, rd);
            end
            chk1("live error", 1'b0, er);
        end
        $display("test live_words done");
        v <= 16'h0033;
        xf(1'b1, 16'h0010, 16'hffff);
        chk1("ro error", 1'b1, er);
        chk16("ro rdata", 16'h0000, rd);
        xf(1'b0, 16'h0010, 16'h0000);
        chk16("ro unchanged", 16'h0033, rd);
        foreach (bad[i]) begin
            xf(1'b0, bad[i], 16'h0000);
            chk1("unmapped error", 1'b1, er);
        end
        $display("test refusals done");
        for (int g = 1; g <= 7; g++) begin
            for (int k = 0; k < 2; k++) begin
                logic [15:0] a;
                a = {5'h12, 3'(g), 8'(k * 255)};
                xf(1'b1, a, a ^ 16'h3c3c);
                chk1("param_wr", 1'b1, O_PARAM_WR);
                chk16("param addr", a, param_addr);
                chk16("param data", a ^ 16'h3c3c, O_PARAM_DATA);
                xf(1'b0, a, 16'h0000);
                chk16("param read", a ^ 16'h3c3c, rd);
            end
        end
        xf(1'b1, 16'h945d, 16'h1111);
        xf(1'b1, 16'h935d, 16'h2222);
        xf(1'b0, 16'h945d, 16'h0000);
        chk16("code 0x5d", 16'h1111, rd);
        $display("test windows done");
        @(posedge I_SYS_CLK);
        I_RESET <= 1'b1;
        repeat (2) @(posedge I_SYS_CLK);
        I_RESET <= 1'b0;
        #1;
        chk16("rerun param_data", 16'h0000, O_PARAM_DATA);
        xf(1'b0, 16'h945d, 16'h0000);
        chk16("param kept", 16'h1111, rd);
        $display("test second_reset done");
        end_sim();
    end
endmodule // test_drive_serial_status_map

bind drive_serial_status_map drive_map_asserts chk (.*);
